// File: src/timer_pkg.sv
package timer_pkg;
   // register byte addresses on the internal bus
   localparam logic [15:0] ADDR_CLK_SEL  = 16'hff41; // count_clock_select
   localparam logic [15:0] ADDR_OUT_CTL  = 16'hff4f; // timer_output_control
   localparam logic [15:0] ADDR_MODE     = 16'hff48; // timer_mode_register
   localparam logic [15:0] ADDR_CMP1     = 16'hff4a; // first compare value
   localparam logic [15:0] ADDR_CMP2     = 16'hff4b; // second compare value
   localparam logic [15:0] ADDR_CNT1     = 16'hff4c; // first_counter, read only
   localparam logic [15:0] ADDR_CNT2     = 16'hff4d; // second_counter, read only
   // reset values
   localparam logic [7:0]  RST_CLK_SEL   = 8'h00;
   localparam logic [7:0]  RST_OUT_CTL   = 8'h00;
   localparam logic [7:0]  RST_MODE      = 8'h00;
   localparam logic [7:0]  RST_CMP       = 8'h00;
   // timer_mode_register fields
   localparam int          MODE_RUN1     = 0;     // first_counter_run
   localparam int          MODE_RUN2     = 1;     // second counter run
   localparam int          MODE_CASCADE  = 2;     // both counters as one 16-bit counter
   // timer_output_control fields
   localparam int          OC_OE1        = 0;     // first_output_enable
   localparam int          OC_INV1       = 1;     // first_invert_enable
   localparam int          OC_CLR1       = 2;     // first_flop_clear
   localparam int          OC_SET1       = 3;     // first_flop_set
   localparam int          OC_OE2        = 4;     // second_output_enable
   localparam int          OC_INV2       = 5;     // second_invert_enable
   localparam int          OC_CLR2       = 6;     // second_flop_clear
   localparam int          OC_SET2       = 7;     // second_flop_set
   localparam logic [7:0]  OC_KEEP_MASK  = 8'h33; // bits that are stored
   // count_clock_select fields
   localparam int          CS_LO1        = 0;     // first_clock_code_lsb
   localparam int          CS_LO2        = 4;     // second_clock_code_lsb
   // clock source codes
   localparam logic [3:0]  CODE_FALL     = 4'h0;
   localparam logic [3:0]  CODE_RISE     = 4'h1;
   localparam logic [3:0]  CODE_DIV2     = 4'h5;
   localparam logic [3:0]  CODE_DIV16    = 4'h8;
   localparam logic [3:0]  CODE_DIV4096  = 4'hf;
   // prescaler of the main clock
   localparam int          PRESC_W       = 12;
   localparam logic [3:0]  SHIFT_DIV2    = 4'h1;
   localparam logic [3:0]  SHIFT_DIV16   = 4'h4;
   localparam logic [3:0]  SHIFT_DIV4096 = 4'hc;
endpackage

// File: src/timer_channel.sv
// one 8-bit counter with its source select, compare and output flop
module timer_channel (
   // clock and reset
   input  wire logic                             mclk_i,
   input  wire logic                             reset_i,
   // control
   input  wire logic                             run_i,
   input  wire logic [3:0]                       code_i,
   input  wire logic [timer_pkg::PRESC_W-1:0]    div_tick_i,
   input  wire logic                             event_i,
   input  wire logic [7:0]                       compare_i,
   // cascade hooks
   input  wire logic                             use_ext_i,
   input  wire logic                             ext_tick_i,
   input  wire logic                             joint_i,
   input  wire logic                             joint_eq_i,
   input  wire logic                             force_clr_i,
   // output flop control
   input  wire logic                             flop_set_i,
   input  wire logic                             flop_clr_i,
   input  wire logic                             invert_en_i,
   // results
   output logic [7:0]                            count_o,
   output logic                                  eq_o,
   output logic                                  carry_o,
   output logic                                  fire_o,
   output logic                                  flop_o
);
   logic [2:0] sync_q;   // [0] first stage, [1] second, [2] history
   logic       own_tick; // selected source tick
   logic       tick;     // tick after cascade choice
   logic       hit;      // match condition
   logic [7:0] count_q;  // first_counter or second_counter
   logic       flop_q;   // first_output_flop or second_output_flop

   // divider shift for a code, zero for edge and prohibited codes
   function automatic logic [3:0] div_shift(input logic [3:0] code);
      if (code >= timer_pkg::CODE_DIV2 && code < timer_pkg::CODE_DIV16) begin
         div_shift = code - timer_pkg::CODE_DIV2 + timer_pkg::SHIFT_DIV2;
      end else if (code >= timer_pkg::CODE_DIV16 && code < timer_pkg::CODE_DIV4096) begin
         div_shift = code - timer_pkg::CODE_DIV16 + timer_pkg::SHIFT_DIV16;
      end else if (code == timer_pkg::CODE_DIV4096) begin
         div_shift = timer_pkg::SHIFT_DIV4096;
      end else begin
         div_shift = 4'h0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // event input: two stages, then one history flop for edge detect
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1], sync_q[0], event_i}; // see (R18)
      end
   end

   // source select; prohibited codes give no tick at all
   always_comb begin
      unique case (code_i)
         timer_pkg::CODE_FALL: own_tick = sync_q[2] & ~sync_q[1]; // see (R1)
         timer_pkg::CODE_RISE: own_tick = ~sync_q[2] & sync_q[1]; // see (R1)
         default: begin
            if (div_shift(code_i) != 4'h0) begin
               own_tick = div_tick_i[div_shift(code_i) - 4'h1]; // see (R1)
            end else begin
               own_tick = 1'b0;
            end
         end
      endcase
   end

   assign tick    = use_ext_i ? ext_tick_i : own_tick;
   assign eq_o    = (count_q == compare_i);
   assign hit     = joint_i ? joint_eq_i : eq_o;
   assign fire_o  = run_i & tick & hit; // see (R16)
   assign carry_o = run_i & tick & (count_q == 8'hff) & ~fire_o;
   assign count_o = count_q;
   assign flop_o  = flop_q;

   ////////////////////////////////////////////////////////////////////////
   // counter: held at zero while stopped, clears on match and keeps going
   always_ff @(posedge mclk_i) begin
      if (reset_i || !run_i) begin
         count_q <= 8'h00;
      end else if (fire_o || force_clr_i) begin
         count_q <= 8'h00; // see (R16)
      end else if (tick) begin
         count_q <= count_q + 8'h01; // see (R18)
      end
   end

   // output flop: software set/clear beats a match toggle
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         flop_q <= 1'b0;
      end else if (flop_set_i) begin
         flop_q <= 1'b1; // see (R11)
      end else if (flop_clr_i) begin
         flop_q <= 1'b0; // see (R11)
      end else if (invert_en_i && fire_o) begin
         flop_q <= ~flop_q; // see (R17)
      end
   end

   a_edge_once: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R18)
      (run_i && !use_ext_i && code_i == timer_pkg::CODE_RISE && !sync_q[2] && sync_q[1] && !hit && !force_clr_i)
      |=> count_o == $past(count_q) + 8'h01)
      else $error("rising edge did not count once");
endmodule

// File: src/dual_timer_ctrl.sv
// Function
// (R1) first counter source: edge or divided clock
// (R2) second counter source, same encoding
// (R3) software stops timers before changing source
// (R4) mode register runs counters, bit/byte writes
// (R5) software stops counters before mode change
// (R6) cascade: first run bit controls both
// (R7) bit 0 enables first timer output
// (R8) bit 4 enables second timer output
// (R9) bit 1 enables first flop inversion
// (R10) bit 5 enables second flop inversion
// (R11) set/clear pairs drive output flops
// (R12) set/clear bits read back as zero
// (R13) software writes output control while stopped
// (R14) output control bit/byte writes, reset zero
// (R15) clock select byte writes only, reset zero
// (R16) match clears counter and raises request
// (R17) match toggles flop; flop drives pin
// (R18) event edges synchronised, counted once
module dual_timer_ctrl (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // internal register bus
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_byte_i,
   input  wire logic        wr_bit_i,
   input  wire logic [2:0]  bit_sel_i,
   input  wire logic        bit_val_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   // event inputs
   input  wire logic        first_event_input_i,
   input  wire logic        second_event_input_i,
   // timer output pins
   output logic             first_tout_o,
   output logic             first_tout_en_o,
   output logic             second_tout_o,
   output logic             second_tout_en_o,
   // match requests
   output logic             first_match_irq_o,
   output logic             second_match_irq_o
);
   logic [7:0]                    count_clock_select_q;   // two source codes
   logic [7:0]                    timer_mode_register_q;  // run bits and mode
   logic [7:0]                    timer_output_control_q; // stored bits only
   logic [7:0]                    cmp1_q;                 // first compare value
   logic [7:0]                    cmp2_q;                 // second compare value
   logic [7:0]                    rdata_q;                // registered read data
   logic [timer_pkg::PRESC_W-1:0] presc_q;                // main clock prescaler
   logic [timer_pkg::PRESC_W-1:0] div_tick;               // one pulse per 2^n cycles
   logic [7:0]                    oc_written;             // output control as written
   logic                          cascade;                // 16-bit mode
   logic                          run1;                   // first run
   logic                          run2;                   // second run
   logic [7:0]                    count1;
   logic [7:0]                    count2;
   logic                          eq1;
   logic                          eq2;
   logic                          carry1;
   logic                          fire1;
   logic                          fire2;
   logic                          flop1;
   logic                          flop2;
   logic                          set1;
   logic                          clr1;
   logic                          set2;
   logic                          clr2;
   logic                          oc_hit;

   // value after a byte write or a single-bit write to a byte
   function automatic logic [7:0] merge_write(input logic [7:0] old, input logic byte_we,
                                              input logic bit_we, input logic [2:0] sel,
                                              input logic val, input logic [7:0] data);
      merge_write = old;
      if (byte_we) begin
         merge_write = data;
      end else if (bit_we) begin
         merge_write[sel] = val;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // count_clock_select: byte writes only, bit writes are ignored
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count_clock_select_q <= timer_pkg::RST_CLK_SEL; // see (R15)
      end else if (wr_byte_i && addr_i == timer_pkg::ADDR_CLK_SEL) begin
         count_clock_select_q <= wdata_i; // see (R15)
      end
   end

   // timer_mode_register: bit or byte writes
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         timer_mode_register_q <= timer_pkg::RST_MODE; // see (R4)
      end else if (addr_i == timer_pkg::ADDR_MODE) begin
         timer_mode_register_q <= merge_write(timer_mode_register_q, wr_byte_i, wr_bit_i,
                                              bit_sel_i, bit_val_i, wdata_i); // see (R4)
      end
   end

   // compare values: byte writes only
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cmp1_q <= timer_pkg::RST_CMP;
         cmp2_q <= timer_pkg::RST_CMP;
      end else if (wr_byte_i) begin
         if (addr_i == timer_pkg::ADDR_CMP1) begin
            cmp1_q <= wdata_i;
         end
         if (addr_i == timer_pkg::ADDR_CMP2) begin
            cmp2_q <= wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output control: set/clear bits are never stored, they act as pulses
   assign oc_hit     = (addr_i == timer_pkg::ADDR_OUT_CTL) && (wr_byte_i || wr_bit_i);
   assign oc_written = merge_write(timer_output_control_q, wr_byte_i, wr_bit_i,
                                   bit_sel_i, bit_val_i, wdata_i);
   // both bits of a pair at once is prohibited and leaves the flop alone
   assign set1 = oc_hit & oc_written[timer_pkg::OC_SET1] & ~oc_written[timer_pkg::OC_CLR1]; // see (R11)
   assign clr1 = oc_hit & oc_written[timer_pkg::OC_CLR1] & ~oc_written[timer_pkg::OC_SET1]; // see (R11)
   assign set2 = oc_hit & oc_written[timer_pkg::OC_SET2] & ~oc_written[timer_pkg::OC_CLR2]; // see (R11)
   assign clr2 = oc_hit & oc_written[timer_pkg::OC_CLR2] & ~oc_written[timer_pkg::OC_SET2]; // see (R11)

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         timer_output_control_q <= timer_pkg::RST_OUT_CTL; // see (R14)
      end else if (oc_hit) begin
         timer_output_control_q <= oc_written & timer_pkg::OC_KEEP_MASK; // see (R12)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port: answer one cycle after the address is presented
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else begin
         unique case (addr_i)
            timer_pkg::ADDR_CLK_SEL: rdata_q <= count_clock_select_q;
            timer_pkg::ADDR_MODE:    rdata_q <= timer_mode_register_q;
            timer_pkg::ADDR_OUT_CTL: rdata_q <= timer_output_control_q; // see (R12)
            timer_pkg::ADDR_CMP1:    rdata_q <= cmp1_q;
            timer_pkg::ADDR_CMP2:    rdata_q <= cmp2_q;
            timer_pkg::ADDR_CNT1:    rdata_q <= count1;
            timer_pkg::ADDR_CNT2:    rdata_q <= count2;
            default:                 rdata_q <= 8'h00;
         endcase
      end
   end
   assign rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // free-running prescaler; bit pattern all ones marks each divided tick
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + 1'b1;
      end
   end

   for (genvar g = 1; g <= timer_pkg::PRESC_W; g++) begin : g_div
      assign div_tick[g-1] = &presc_q[g-1:0]; // see (R1)
   end

   // in cascade the second run bit is ignored; the first starts both
   assign cascade = timer_mode_register_q[timer_pkg::MODE_CASCADE];
   assign run1    = timer_mode_register_q[timer_pkg::MODE_RUN1];
   assign run2    = cascade ? run1 : timer_mode_register_q[timer_pkg::MODE_RUN2]; // see (R6)

   ////////////////////////////////////////////////////////////////////////
   // first counter: low byte in cascade, matches on both bytes
   timer_channel u_first (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .run_i       (run1),
      .code_i      (count_clock_select_q[timer_pkg::CS_LO1 +: 4]),
      .div_tick_i  (div_tick),
      .event_i     (first_event_input_i),
      .compare_i   (cmp1_q),
      .use_ext_i   (1'b0),
      .ext_tick_i  (1'b0),
      .joint_i     (cascade),
      .joint_eq_i  (eq1 & eq2),
      .force_clr_i (1'b0),
      .flop_set_i  (set1),
      .flop_clr_i  (clr1),
      .invert_en_i (timer_output_control_q[timer_pkg::OC_INV1]), // see (R9)
      .count_o     (count1),
      .eq_o        (eq1),
      .carry_o     (carry1),
      .fire_o      (fire1),
      .flop_o      (flop1)
   );

   // second counter: high byte in cascade, counting the first's carry
   timer_channel u_second (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .run_i       (run2),
      .code_i      (count_clock_select_q[timer_pkg::CS_LO2 +: 4]), // see (R2)
      .div_tick_i  (div_tick),
      .event_i     (second_event_input_i),
      .compare_i   (cmp2_q),
      .use_ext_i   (cascade),
      .ext_tick_i  (carry1),
      .joint_i     (cascade),
      .joint_eq_i  (1'b0),
      .force_clr_i (cascade & fire1),
      .flop_set_i  (set2),
      .flop_clr_i  (clr2),
      .invert_en_i (timer_output_control_q[timer_pkg::OC_INV2]), // see (R10)
      .count_o     (count2),
      .eq_o        (eq2),
      .carry_o     (),
      .fire_o      (fire2),
      .flop_o      (flop2)
   );

   ////////////////////////////////////////////////////////////////////////
   // pins: disabled outputs leave the pin to the port logic
   assign first_tout_en_o    = timer_output_control_q[timer_pkg::OC_OE1]; // see (R7)
   assign first_tout_o       = first_tout_en_o & flop1; // see (R17)
   assign second_tout_en_o   = timer_output_control_q[timer_pkg::OC_OE2]; // see (R8)
   assign second_tout_o      = second_tout_en_o & flop2; // see (R17)
   assign first_match_irq_o  = fire1; // see (R16)
   assign second_match_irq_o = fire2; // see (R16)

   ////////////////////////////////////////////////////////////////////////
   a_clksel_byte_only: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R15)
      (wr_bit_i && !wr_byte_i && addr_i == timer_pkg::ADDR_CLK_SEL) |=> $stable(count_clock_select_q))
      else $error("bit write changed clock select");

   a_sr_read_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R12)
      ($past(addr_i) == timer_pkg::ADDR_OUT_CTL && !$past(reset_i)) |-> (rdata_o & 8'hcc) == 8'h00)
      else $error("set or clear bit read back nonzero");

   a_flop_set: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R11)
      (oc_hit && wr_byte_i && wdata_i[3:2] == 2'b10) |=> flop1 ##1 flop1 || $past(fire1))
      else $error("first flop not set");

   a_flop_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R11)
      (oc_hit && wr_byte_i && wdata_i[7:6] == 2'b01) |=> !flop2)
      else $error("second flop not cleared");

   a_flop_both_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R11)
      (oc_hit && wr_byte_i && wdata_i[3:2] == 2'b11 && !fire1) |=> flop1 == $past(flop1))
      else $error("prohibited pair changed flop");

   a_out_gate: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R7)
      !timer_output_control_q[timer_pkg::OC_OE1] |-> !first_tout_o && !first_tout_en_o)
      else $error("disabled first output driven");

   a_invert_toggle: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R9)
      (fire1 && timer_output_control_q[timer_pkg::OC_INV1] && !set1 && !clr1) |=> flop1 != $past(flop1))
      else $error("match did not toggle first flop");

   a_no_invert: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R10)
      (!timer_output_control_q[timer_pkg::OC_INV2] && !set2 && !clr2) |=> $stable(flop2))
      else $error("second flop moved without inversion");

   a_cascade_run: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R6)
      (cascade && !run1) [*2] |-> count2 == 8'h00 && count1 == 8'h00)
      else $error("cascade ran without first run bit");

   a_match_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // see (R16)
      (first_match_irq_o && $stable(timer_mode_register_q)) |=> count1 == 8'h00)
      else $error("match did not clear first counter");

   a_mode_reset: assert property (@(posedge mclk_i) // see (R4)
      reset_i |=> timer_mode_register_q == 8'h00 && timer_output_control_q == 8'h00)
      else $error("control not cleared by reset");
endmodule

// File: tb/test_dual_timer_clock_and_output_control.sv
////////////////////////////////////////////////////////////////////////////////
// one compare: counts every call, reports and counts every miss
`define check_eq(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH %s expected %h seen %h", name, exp, got); end end

module test_dual_timer_clock_and_output_control;
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   // stimulus and observed pins
   logic        mclk_i  = 1'b0;  // 20 MHz main clock
   logic        reset_i = 1'b1;  // synchronous, held at start
   logic [15:0] addr    = 16'h0000;
   logic        wr_b    = 1'b0;  // byte write strobe
   logic        wr_bt   = 1'b0;  // bit write strobe
   logic [2:0]  bsel    = 3'h0;
   logic        bval    = 1'b0;
   logic [7:0]  wdat    = 8'h00;
   logic        ev1     = 1'b0;  // first event pin
   logic        ev2     = 1'b0;  // second event pin
   logic [7:0]  rdata;
   logic        t1, e1, t2, e2, i1, i2;
   int          num_errors = 0;
   int          num_checks = 0;
   int          n1 = 0;          // running count of first match pulses
   int          n2 = 0;          // running count of second match pulses
   // register rows: address, byte written, value read back
   typedef struct { logic [15:0] a; logic [7:0] d; logic [7:0] e; } row_t;
   row_t        rows [6] = '{'{16'hff41, 8'ha5, 8'ha5}, '{16'hff4f, 8'hff, 8'h33},
                            '{16'hff48, 8'hf8, 8'hf8}, '{16'hff4a, 8'h7e, 8'h7e},
                            '{16'hff40, 8'h55, 8'h00}, '{16'hff4c, 8'h12, 8'h00}};

   always #25 mclk_i = ~mclk_i;

   // pulses stand one cycle, so one look per edge counts each exactly once
   always @(posedge mclk_i) begin
      if (i1 === 1'b1) n1++;
      if (i2 === 1'b1) n2++;
   end

   dual_timer_ctrl uut (
      .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wr_byte_i(wr_b), .wr_bit_i(wr_bt),
      .bit_sel_i(bsel), .bit_val_i(bval), .wdata_i(wdat), .rdata_o(rdata),
      .first_event_input_i(ev1), .second_event_input_i(ev2),
      .first_tout_o(t1), .first_tout_en_o(e1), .second_tout_o(t2), .second_tout_en_o(e2),
      .first_match_irq_o(i1), .second_match_irq_o(i2));

   ////////////////////////////////////////////////////////////////////////////////
   // bus tasks: strobes rise on one edge, fall on the next
   // each returns just after the write edge, so pins are settled when looked at
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a; wdat <= d; wr_b <= 1'b1;
      @(posedge mclk_i);
      wr_b <= 1'b0;
      #1;
   endtask
   task automatic wbit(input logic [15:0] a, input logic [2:0] s, input logic v);
      @(posedge mclk_i);
      addr <= a; bsel <= s; bval <= v; wr_bt <= 1'b1;
      @(posedge mclk_i);
      wr_bt <= 1'b0;
      #1;
   endtask
   // read data is registered, so look two edges after the address lands
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      repeat (2) @(posedge mclk_i);
      #1 d = rdata;
   endtask
   // bounded wait for a match pulse; n gives the cycles it took
   task automatic wait_irq(input int w, output int n);
      n = 0;
      do begin
         @(posedge mclk_i);
         #1 n++;
      end while (((w == 1) ? i1 : i2) !== 1'b1 && n < 200);
      if (n >= 200) begin
         num_errors++;
         $display("MISMATCH match pulse expected 1 seen 0");
         stop_test();
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      int         n, k;
      logic       t;
      repeat (16) @(posedge mclk_i);
      reset_i <= 1'b0;
      rd(16'hff41, v); `check_eq("clock select reset", 8'h00, v)
      rd(16'hff4f, v); `check_eq("output control reset", 8'h00, v)
      rd(16'hff48, v); `check_eq("mode reset", 8'h00, v)
      `check_eq("pins after reset", 4'h0, {e1, t1, e2, t2})
      $display("test reset done");
      // plain byte writes and read-back, unmapped and read-only places included
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v); `check_eq("register row", rows[i].e, v)
      end
      // set and clear together left both flops at zero
      `check_eq("pins after ff", 4'ha, {e1, t1, e2, t2})
      wr(16'hff48, 8'h00); // stopped before any control write
      wr(16'hff41, 8'h00);
      $display("test register rows done");
      // flop set/clear commands against the output enables, all while stopped
      wr(16'hff4f, 8'h09); `check_eq("set first", 4'hc, {e1, t1, e2, t2})
      wr(16'hff4f, 8'h04); `check_eq("clear first", 4'h0, {e1, t1, e2, t2})
      wr(16'hff4f, 8'h98); `check_eq("set both", 4'h3, {e1, t1, e2, t2})
      wr(16'hff4f, 8'h50); `check_eq("clear second", 4'h2, {e1, t1, e2, t2})
      wbit(16'hff4f, 3'h0, 1'b1); `check_eq("bit enable", 2'b11, {e1, t1})
      rd(16'hff4f, v); `check_eq("command bits read", 8'h11, v)
      wbit(16'hff41, 3'h0, 1'b1);
      rd(16'hff41, v); `check_eq("bit write select", 8'h00, v)
      wbit(16'hff48, 3'h1, 1'b1);
      rd(16'hff48, v); `check_eq("bit write mode", 8'h02, v)
      wbit(16'hff48, 3'h1, 1'b0);
      $display("test flop commands done");
      // interval: first on main/2 compare 2, second on main/16 compare 1
      wr(16'hff4f, 8'h33);
      wr(16'hff41, 8'h85);
      wr(16'hff4a, 8'h02);
      wr(16'hff4b, 8'h01);
      wr(16'hff48, 8'h03);
      wait_irq(1, n);
      wait_irq(1, n); `check_eq("first period", 6, n)
      @(posedge mclk_i);
      #1 t = t1;
      wait_irq(1, n);
      @(posedge mclk_i);
      #1 `check_eq("first toggle", ~t, t1)
      wait_irq(2, n);
      wait_irq(2, n); `check_eq("second period", 32, n)
      $display("test interval done");
      // events: first counts rising to compare 2, so 3 edges give one match
      // second counts falling with compare 0, one match per edge
      wr(16'hff48, 8'h00);
      wr(16'hff41, 8'h01);
      wr(16'hff4a, 8'h02);
      wr(16'hff4b, 8'h00);
      wr(16'hff48, 8'h03);
      k = n1;
      n = n2;
      repeat (3) begin
         @(posedge mclk_i);
         ev1 <= 1'b1; ev2 <= 1'b1;
         repeat (5) @(posedge mclk_i);
         ev1 <= 1'b0; ev2 <= 1'b0;
         repeat (5) @(posedge mclk_i);
      end
      repeat (5) @(posedge mclk_i);
      `check_eq("rising events", k + 1, n1)
      `check_eq("falling events", n + 3, n2)
      // prohibited code 2 must never tick
      wr(16'hff48, 8'h00);
      wr(16'hff41, 8'h22);
      wr(16'hff48, 8'h03);
      k = n1;
      n = n2;
      repeat (40) @(posedge mclk_i);
      `check_eq("prohibited first", k, n1)
      `check_eq("prohibited second", n, n2)
      $display("test events done");
      // cascade: the second run bit alone must not start the pair
      wr(16'hff48, 8'h00);
      wr(16'hff41, 8'h55);
      wr(16'hff48, 8'h06);
      k = n1;
      repeat (20) @(posedge mclk_i);
      #1 `check_eq("cascade held", k, n1)
      // first run bit alone runs it; compares 2 and 0 give one match per 6 cycles
      wr(16'hff48, 8'h05);
      repeat (10) @(posedge mclk_i);
      #1 k = n1;
      n = n2;
      repeat (42) @(posedge mclk_i);
      #1 `check_eq("cascade first", k + 7, n1)
      `check_eq("cascade second", n, n2)
      $display("test cascade done");
      stop_test();
   end
endmodule
